/* hdl/adccal_defs.svh */
// Purpose: Offsets, fields, reset values and timing counts of the calibration control
// Assumes: Included by bare name from design files
// Notes:   Register index times four gives the byte address
`ifndef ADCCAL_DEFS_SVH
`define ADCCAL_DEFS_SVH

// Register indices (byte address = index * 4)
`define ADCCAL_IDX_CTRL     4'h1
`define ADCCAL_IDX_FSADJ    4'h2
`define ADCCAL_IDX_STAT     4'h3
`define ADCCAL_IDX_IRQ      4'h4
`define ADCCAL_IDX_MASK     4'h5

// Fields
`define ADCCAL_TRIM_DIS_BIT 13
`define ADCCAL_IRQ_DONE     0
`define ADCCAL_IRQ_START    1
`define ADCCAL_IRQ_IGN      2

// Reset values and full-scale codes
`define ADCCAL_CTRL_RST     16'h0000
`define ADCCAL_FSADJ_RST    8'h80
`define ADCCAL_MASK_RST     3'h0
`define ADCCAL_FS_NORMAL    8'hff
`define ADCCAL_FS_REDUCED   8'h80

// Timing counts in input clock cycles
`define ADCCAL_DLY_SHORT_CYC 32'd8192
`define ADCCAL_DLY_LONG_CYC  32'd65536
`define ADCCAL_TRIM_CYC      32'd512
`define ADCCAL_CONV_CYC      32'd2048
`define ADCCAL_REQ_LO_CYC    32'd80
`define ADCCAL_REQ_HI_CYC    32'd80
`define ADCCAL_BOOT_CYC      2'd3

`endif

/* hdl/adccal_pkg.sv */
// Purpose: Types of the calibration control
// Assumes: Constants live in adccal_defs.svh
// Notes:   One-hot sequencer states
package adccal_pkg;

   typedef enum logic [4:0] {
      ST_BOOT  = 5'b00001,
      ST_DELAY = 5'b00010,
      ST_IDLE  = 5'b00100,
      ST_TRIM  = 5'b01000,
      ST_CONV  = 5'b10000
   } adccal_state_e;

   typedef struct packed {
      adccal_state_e st;
      logic [23:0]   cnt;
      logic [1:0]    boot;
      logic          pon;
      logic [15:0]   ctrl;
      logic [7:0]    fsadj;
      logic [2:0]    irq;
      logic [2:0]    mask;
      logic          wait_r;
      logic [31:0]   rdata;
      logic          cal_run;
      logic          out_data_clock_en;
      logic          apd;
      logic          trim;
      logic [7:0]    fs_code;
      logic          irq_out;
   } adccal_top_s;

endpackage

/* hdl/adccal_sync.sv */
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Bits are independent levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module adccal_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } adccal_sync_s;

   adccal_sync_s q, n;

   // Shift pin levels through two stages
   always_comb begin
      n    = q;
      n.s1 = d_i;
      n.s2 = q.s1;
   end

   // State register
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign q_o = q.s2;
endmodule

/* hdl/adccal_req_qual.sv */
// Purpose: Qualifies the calibration request pin by low and high cycle counts
// Assumes: Request input is already synchronised
// Notes:   Start is a one-cycle pulse from a register
`timescale 1ns/10ps
module adccal_req_qual #(
   parameter int unsigned LO_CYC = 80,
   parameter int unsigned HI_CYC = 80,
   parameter int unsigned CW     = 16
) (
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   input  wire logic req_i,
   output logic      start_o
);
   localparam logic [CW-1:0] LO_MAX = CW'(LO_CYC);
   localparam logic [CW-1:0] HI_END = CW'(HI_CYC - 1);

   typedef struct packed {
      logic [CW-1:0] lo_cnt;
      logic [CW-1:0] hi_cnt;
      logic          start;
   } adccal_qual_s;

   adccal_qual_s q, n;

   // Separate low and high counters gate the start pulse
   always_comb begin
      n       = q;
      n.start = 1'b0;
      if (!req_i) begin
         n.hi_cnt = '0;
         if (q.hi_cnt != '0) begin
            // A cut high phase restarts the low period
            n.lo_cnt = CW'(1);
         end else if (q.lo_cnt != LO_MAX) begin
            n.lo_cnt = q.lo_cnt + CW'(1);
         end
      end else if (q.lo_cnt == LO_MAX) begin
         if (q.hi_cnt == HI_END) begin
            n.start  = 1'b1;
            n.lo_cnt = '0;
            n.hi_cnt = '0;
         end else begin
            n.hi_cnt = q.hi_cnt + CW'(1);
         end
      end else begin
         n.lo_cnt = '0;
      end
   end

   // State register
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign start_o = q.start;
endmodule

/* hdl/adccal_top.sv */
// Purpose: Range select, calibration sequencer and register slave of a dual converter
// Assumes: Pins are asynchronous to core_clk_i; reset stands for power-up
// Notes:   Avalon-MM slave answers one cycle after the request is seen
`timescale 1ns/10ps
`include "adccal_defs.svh"

module adccal_top #(
   parameter int unsigned DLY_SHORT_CYC = `ADCCAL_DLY_SHORT_CYC,
   parameter int unsigned DLY_LONG_CYC  = `ADCCAL_DLY_LONG_CYC,
   parameter int unsigned TRIM_CYC      = `ADCCAL_TRIM_CYC,
   parameter int unsigned CONV_CYC      = `ADCCAL_CONV_CYC,
   parameter int unsigned REQ_LO_CYC    = `ADCCAL_REQ_LO_CYC,
   parameter int unsigned REQ_HI_CYC    = `ADCCAL_REQ_HI_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Control pins
   input  wire logic        range_select_i,
   input  wire logic        cal_req_i,
   input  wire logic        cal_delay_select_i,
   input  wire logic        power_down_in_i,
   input  wire logic        ext_mode_i,
   input  wire logic        clk_present_i,
   // Converter controls
   output logic             cal_running_o,
   output logic             out_data_clock_en_o,
   output logic             analog_pd_o,
   output logic             term_trim_o,
   output logic      [7:0]  fs_code_o,
   output logic             irq_o
);
   // Counter loads; delay, trim and conversion states count their load down to zero
   localparam int unsigned CW = 24;
   localparam logic [CW-1:0] DLY_S_LD = CW'(DLY_SHORT_CYC - 1);
   localparam logic [CW-1:0] DLY_L_LD = CW'(DLY_LONG_CYC - 1);
   localparam logic [CW-1:0] TRIM_LD  = CW'(TRIM_CYC - 1);
   localparam logic [CW-1:0] CONV_LD  = CW'(CONV_CYC - 1);

   // Positions of the pins in the synchroniser vector
   localparam int unsigned PIN_RANGE = 0;
   localparam int unsigned PIN_REQ   = 1;
   localparam int unsigned PIN_DLY   = 2;
   localparam int unsigned PIN_PD    = 3;
   localparam int unsigned PIN_EXT   = 4;
   localparam int unsigned PIN_CLK   = 5;

   // Whole state of the block and its next value
   adccal_pkg::adccal_top_s q, n;

   // Raw and synchronised pin levels
   logic [5:0]  pin_raw;
   logic [5:0]  pin_s;
   logic        range_s;
   logic        req_s;
   logic        dly_s;
   logic        pd_s;
   logic        ext_s;
   logic        clk_ok_s;

   // Qualified request start and bus decode
   logic        qual_start;
   logic        req;
   logic        acc;
   logic [3:0]  idx;
   logic [31:0] rd_val;
   logic        trim_dis;

   // One-cycle sequencer events for the sticky flags
   logic        ev_done;
   logic        ev_start;
   logic        ev_ign;

   // Gather the asynchronous pins into one vector
   always_comb begin
      pin_raw            = '0;
      pin_raw[PIN_RANGE] = range_select_i;
      pin_raw[PIN_REQ]   = cal_req_i;
      pin_raw[PIN_DLY]   = cal_delay_select_i;
      pin_raw[PIN_PD]    = power_down_in_i;
      pin_raw[PIN_EXT]   = ext_mode_i;
      pin_raw[PIN_CLK]   = clk_present_i;
   end

   // Pin levels into the clock domain; nothing reads the first stage
   adccal_sync #(
      .W (6)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .d_i        (pin_raw),
      .q_o        (pin_s)
   );

   // Synchronised levels by name
   assign range_s  = pin_s[PIN_RANGE];
   assign req_s    = pin_s[PIN_REQ];
   assign dly_s    = pin_s[PIN_DLY];
   assign pd_s     = pin_s[PIN_PD];
   assign ext_s    = pin_s[PIN_EXT];
   assign clk_ok_s = pin_s[PIN_CLK];

   // Request pin qualification
   adccal_req_qual #(
      .LO_CYC (REQ_LO_CYC),
      .HI_CYC (REQ_HI_CYC),
      .CW     (16)
   ) u_qual (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .req_i      (req_s),
      .start_o    (qual_start)
   );

   // Bus decode helpers
   assign req      = avs_read_i | avs_write_i;
   assign acc      = req & ~q.wait_r;
   assign idx      = avs_address_i[5:2];
   assign trim_dis = q.ctrl[`ADCCAL_TRIM_DIS_BIT];

   // Read mux; unmapped indices read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (idx)
         `ADCCAL_IDX_CTRL: begin
            rd_val[15:0] = q.ctrl;
         end
         `ADCCAL_IDX_FSADJ: begin
            rd_val[7:0] = q.fsadj;
         end
         `ADCCAL_IDX_STAT: begin
            rd_val[4:0]   = q.st;
            rd_val[8]     = q.cal_run;
            rd_val[9]     = q.pon;
            rd_val[10]    = q.apd;
            rd_val[11]    = q.out_data_clock_en;
            rd_val[12]    = ext_s;
            rd_val[13]    = pd_s;
            rd_val[23:16] = q.fs_code;
         end
         `ADCCAL_IDX_IRQ: begin
            rd_val[2:0] = q.irq;
         end
         `ADCCAL_IDX_MASK: begin
            rd_val[2:0] = q.mask;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // Next state of the whole block
   always_comb begin
      n        = q;
      ev_done  = 1'b0;
      ev_start = 1'b0;
      ev_ign   = 1'b0;

      // Bus handshake: accept, then answer one cycle later
      n.wait_r = 1'b1;
      if (req && q.wait_r) begin
         n.wait_r = 1'b0;
         n.rdata  = rd_val;
      end

      // Register writes at the answering edge
      if (acc && avs_write_i) begin
         case (idx)
            `ADCCAL_IDX_CTRL: begin
               if (ext_s) begin
                  if (avs_byteenable_i[0]) begin
                     n.ctrl[7:0] = avs_writedata_i[7:0];
                  end
                  if (avs_byteenable_i[1]) begin
                     n.ctrl[15:8] = avs_writedata_i[15:8];
                  end
               end
            end
            `ADCCAL_IDX_FSADJ: begin
               if (avs_byteenable_i[0]) begin
                  n.fsadj = avs_writedata_i[7:0];
               end
            end
            `ADCCAL_IDX_MASK: begin
               if (avs_byteenable_i[0]) begin
                  n.mask = avs_writedata_i[2:0];
               end
            end
            default: begin
               n.mask = q.mask;
            end
         endcase
      end

      // Calibration sequencer
      case (q.st)
         // Boot: let the pins settle, then choose the path
         adccal_pkg::ST_BOOT: begin
            n.pon  = 1'b1;
            n.boot = q.boot + 2'd1;
            if (q.boot == `ADCCAL_BOOT_CYC) begin
               if (req_s) begin
                  n.st  = adccal_pkg::ST_IDLE;
                  n.pon = 1'b0;
               end else begin
                  n.st  = adccal_pkg::ST_DELAY;
                  n.cnt = (dly_s && !ext_s) ? DLY_L_LD : DLY_S_LD;
               end
            end
         end
         adccal_pkg::ST_DELAY: begin
            // Delay advances only with power-down low and the clock running
            if (!pd_s && clk_ok_s) begin
               if (q.cnt == '0) begin
                  n.st     = adccal_pkg::ST_TRIM;
                  n.cnt    = TRIM_LD;
                  ev_start = 1'b1;
               end else begin
                  n.cnt = q.cnt - CW'(1);
               end
            end
         end
         // Idle: a qualified request starts a calibration unless powered down
         adccal_pkg::ST_IDLE: begin
            if (qual_start) begin
               if (pd_s) begin
                  ev_ign = 1'b1;
               end else begin
                  ev_start = 1'b1;
                  n.pon    = 1'b0;
                  if (trim_dis) begin
                     n.st  = adccal_pkg::ST_CONV;
                     n.cnt = CONV_LD;
                  end else begin
                     n.st  = adccal_pkg::ST_TRIM;
                     n.cnt = TRIM_LD;
                  end
               end
            end
         end
         // Termination trim step, then conversion calibration
         adccal_pkg::ST_TRIM: begin
            if (q.cnt == '0) begin
               n.st  = adccal_pkg::ST_CONV;
               n.cnt = CONV_LD;
            end else begin
               n.cnt = q.cnt - CW'(1);
            end
         end
         // Conversion calibration, then back to idle with a done event
         adccal_pkg::ST_CONV: begin
            if (q.cnt == '0) begin
               n.st    = adccal_pkg::ST_IDLE;
               n.pon   = 1'b0;
               ev_done = 1'b1;
            end else begin
               n.cnt = q.cnt - CW'(1);
            end
         end
         default: begin
            n.st = adccal_pkg::ST_BOOT;
         end
      endcase

      // Registered outputs follow the next state
      n.cal_run = (n.st == adccal_pkg::ST_TRIM) || (n.st == adccal_pkg::ST_CONV);
      n.trim    = (n.st == adccal_pkg::ST_TRIM);
      n.out_data_clock_en = !n.cal_run || n.ctrl[`ADCCAL_TRIM_DIS_BIT];
      // Pin power-down only once no calibration runs; no clock powers down whenever pon is set
      n.apd     = (pd_s && !n.cal_run)
                  || (!clk_ok_s && n.pon);
      // Full scale from the register in extended mode, else from the pin
      if (ext_s) begin
         n.fs_code = n.fsadj;
      end else begin
         n.fs_code = range_s ? `ADCCAL_FS_NORMAL : `ADCCAL_FS_REDUCED;
      end

      // Sticky events; a read clears only the bits it returned, a new event wins
      if (acc && avs_read_i && idx == `ADCCAL_IDX_IRQ) begin
         n.irq = q.irq & ~q.rdata[2:0];
      end
      n.irq[`ADCCAL_IRQ_DONE]  = n.irq[`ADCCAL_IRQ_DONE] | ev_done;
      n.irq[`ADCCAL_IRQ_START] = n.irq[`ADCCAL_IRQ_START] | ev_start;
      n.irq[`ADCCAL_IRQ_IGN]   = n.irq[`ADCCAL_IRQ_IGN] | ev_ign;
      // Level interrupt while an unmasked bit stands
      n.irq_out = |(n.irq & n.mask);
   end

   // State register
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         q         <= '0;
         q.st      <= adccal_pkg::ST_BOOT;
         q.pon     <= 1'b1;
         q.ctrl    <= `ADCCAL_CTRL_RST;
         q.fsadj   <= `ADCCAL_FSADJ_RST;
         q.mask    <= `ADCCAL_MASK_RST;
         q.wait_r  <= 1'b1;
         q.out_data_clock_en <= 1'b1;
         q.fs_code <= `ADCCAL_FS_REDUCED;
      end else begin
         q <= n;
      end
   end

   // Bus outputs straight from the state register
   assign avs_readdata_o      = q.rdata;
   assign avs_waitrequest_o   = q.wait_r;

   // Converter controls straight from the state register
   assign cal_running_o       = q.cal_run;
   assign out_data_clock_en_o = q.out_data_clock_en;
   assign analog_pd_o         = q.apd;
   assign term_trim_o         = q.trim;
   assign fs_code_o           = q.fs_code;
   assign irq_o               = q.irq_out;
endmodule

/* tb/adccal_top_asserts.sv */
// Purpose: Port assertions of the calibration control
// Assumes: Sees only adccal_top ports
// Notes:   Pin checks allow two sync flops and one output flop
`timescale 1ns/10ps
module adccal_top_chk #(
   parameter int unsigned TRIM_CYC = 512,
   parameter int unsigned CONV_CYC = 2048
) (
   input wire logic       core_clk_i,
   input wire logic       rst_b_i,
   input wire logic       range_select_i,
   input wire logic       power_down_in_i,
   input wire logic       ext_mode_i,
   input wire logic       clk_present_i,
   input wire logic       cal_running_o,
   input wire logic       out_data_clock_en_o,
   input wire logic       analog_pd_o,
   input wire logic       term_trim_o,
   input wire logic [7:0] fs_code_o
);
   logic [15:0] run_q;
   logic [15:0] trm_len_q;
   logic        trm_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   // Lengths of the current calibration and trim step, and whether it trimmed
   always_ff @(posedge core_clk_i) begin
      run_q     <= (rst_b_i && cal_running_o) ? run_q + 16'h0001 : 16'h0000;
      trm_len_q <= (rst_b_i && term_trim_o) ? trm_len_q + 16'h0001 : 16'h0000;
      trm_q     <= rst_b_i && cal_running_o && (trm_q || term_trim_o);
   end

   AST_FS_NORM: assert property ((!ext_mode_i && range_select_i) [*5] |-> fs_code_o == 8'hff)
      else $error("full scale not normal");
   AST_FS_RED: assert property ((!ext_mode_i && !range_select_i) [*5] |-> fs_code_o == 8'h80)
      else $error("full scale not reduced");
   AST_RUN_LEN: assert property ($fell(cal_running_o) |-> run_q == (trm_q ? TRIM_CYC + CONV_CYC : CONV_CYC))
      else $error("calibration length wrong");
   AST_TRIM_LEN: assert property ($fell(term_trim_o) |-> trm_len_q == TRIM_CYC)
      else $error("trim step length wrong");
   AST_TRIM_RUN: assert property (term_trim_o |-> cal_running_o)
      else $error("trim outside calibration");
   AST_OUT_DATA_CLOCK_TRIM: assert property (term_trim_o |-> !out_data_clock_en_o)
      else $error("data clock runs during trim");
   AST_OUT_DATA_CLOCK_IDLE: assert property (!cal_running_o |-> out_data_clock_en_o)
      else $error("data clock stopped when idle");
   AST_PD_RUN: assert property (clk_present_i [*4] ##0 cal_running_o |-> !analog_pd_o)
      else $error("powered down during calibration");
   AST_PD_IDLE: assert property ((power_down_in_i && !cal_running_o) [*4] |-> analog_pd_o)
      else $error("power down not taken");
endmodule

bind adccal_top adccal_top_chk #(.TRIM_CYC(TRIM_CYC), .CONV_CYC(CONV_CYC)) u_chk (.core_clk_i, .rst_b_i,
   .range_select_i, .power_down_in_i, .ext_mode_i, .clk_present_i, .cal_running_o,
   .out_data_clock_en_o, .analog_pd_o, .term_trim_o, .fs_code_o);

/* tb/adccal_ctl_model.sv */
// Purpose: Outside controller driving the calibration request pin
// Assumes: Shares the converter clock
// Notes:   Pin stays at the level of the last phase
`timescale 1ns/10ps
module adccal_ctl_model (
   input  wire logic core_clk_i,
   output logic      cal_req_o
);
   initial cal_req_o = 1'h0;

   // Low phase then high phase, whole clock cycles each
   task automatic pulse(input int lo, input int hi);
      repeat (lo) @(posedge core_clk_i) cal_req_o <= 1'h0;
      repeat (hi) @(posedge core_clk_i) cal_req_o <= 1'h1;
   endtask
endmodule

/* tb/adc_calibration_control_tb_top.sv */
// Purpose: Self-checking bench of the calibration control
// Assumes: Counts shortened through the top parameters
// Notes:   Expected values come from the local counts
`timescale 1ns/10ps
`include "adccal_defs.svh"
module adc_calibration_control_tb_top;
   localparam int SH = 20, LG = 40, TR = 8, CV = 16, LO = 4, HI = 4;
   logic        clk = 1'h0, rst_b = 1'h0, rd = 1'h0, wr = 1'h0;
   logic        rng = 1'h1, ds = 1'h0, pd = 1'h0, ext = 1'h0, cp = 1'h1;
   logic        wt, cr, dce, apd, tt, irq, req;
   logic [5:0]  ad = 6'h00;
   logic [7:0]  fs;
   logic [31:0] wd = 32'h0, rdat, q, r;
   int          n_fail = 0, checks = 0, cyc = 0, d, l, i, stp;
   integer      seed = 32'h8dada424;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   adccal_top #(.DLY_SHORT_CYC(SH), .DLY_LONG_CYC(LG), .TRIM_CYC(TR), .CONV_CYC(CV),
      .REQ_LO_CYC(LO), .REQ_HI_CYC(HI)) u_dut (
      .core_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
      .range_select_i(rng), .cal_req_i(req), .cal_delay_select_i(ds), .power_down_in_i(pd),
      .ext_mode_i(ext), .clk_present_i(cp), .cal_running_o(cr), .out_data_clock_en_o(dce),
      .analog_pd_o(apd), .term_trim_o(tt), .fs_code_o(fs), .irq_o(irq));
   adccal_ctl_model u_ctl (.core_clk_i(clk), .cal_req_o(req));

   // Cycle ceiling against a hung wait
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_fail++;
         tally_and_finish;
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   // Avalon-MM cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] x, input logic [31:0] v, output logic [31:0] o);
      @(posedge clk);
      ad <= {x, 2'h0};
      wr <= w;
      rd <= !w;
      wd <= v;
      do @(posedge clk); while (wt !== 1'h0);
      o = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask

   // Power-up with the given pin levels
   task automatic reset(input logic rq, input logic s, input logic e, input logic c);
      @(posedge clk);
      rst_b <= 1'h0;
      ds <= s;
      ext <= e;
      cp <= c;
      u_ctl.pulse(!rq, rq);
      repeat (16) @(posedge clk);
      rst_b <= 1'h1;
   endtask

   // Wait for the running output, then time it
   task automatic wrun(input int lim, output int dly, output int len);
      dly = 0;
      len = 0;
      stp = 0;
      while (cr !== 1'h1 && dly < lim) begin
         @(posedge clk);
         dly++;
      end
      while (cr === 1'h1) begin
         if (dce !== 1'h1) stp = 1;
         @(posedge clk);
         len++;
      end
   endtask

   initial begin
      // Power-on calibration with long delay, then done interrupt
      reset(0, 1, 0, 1);
      wrun(200, d, l);
      chk("pon_dly", 1, d > LG && d <= LG + 12);
      chk("pon_len", TR + CV, l);
      bus(0, 4'h5, 0, q);
      chk("mask_rst", 0, q);
      bus(1, 4'h5, 32'h1, q);
      repeat (2) @(posedge clk);
      chk("irq_on", 1, irq);
      bus(0, 4'h4, 0, q);
      chk("irq_done", 1, q[0]);
      repeat (2) @(posedge clk);
      chk("irq_off", 0, irq);
      // Extended mode ignores the delay select
      reset(0, 1, 1, 1);
      wrun(200, d, l);
      chk("ext_dly", 1, d > SH && d <= SH + 12);
      // Request pin high at power-up skips calibration
      reset(1, 0, 0, 1);
      wrun(100, d, l);
      chk("skip", 0, l);
      bus(0, 4'h3, 0, q);
      chk("idle", 5'h04, q[4:0]);
      // Short low or high pulses are noise
      for (i = 0; i < 4; i++) begin
         u_ctl.pulse(1 + {$random(seed)} % (LO - 1), HI);
         u_ctl.pulse(LO, 1 + {$random(seed)} % (HI - 1));
      end
      u_ctl.pulse(1, 0);
      wrun(40, d, l);
      chk("noise", 0, l);
      // Qualified request trims, stops the data clock
      u_ctl.pulse(LO, 1);
      wrun(30, d, l);
      chk("req_dly", 1, d >= HI && d <= HI + 6);
      chk("req_len", TR + CV, l);
      chk("out_data_clock_stop", 1, stp);
      // Trim disable locked in normal mode, taken in extended
      bus(1, 4'h1, 32'h2000, q);
      bus(0, 4'h1, 0, q);
      chk("ctrl_lock", 0, q);
      ext <= 1'h1;
      repeat (3) @(posedge clk);
      bus(1, 4'h1, 32'h2000, q);
      bus(0, 4'h1, 0, q);
      chk("ctrl_set", 32'h2000, q);
      u_ctl.pulse(LO, 1);
      wrun(30, d, l);
      chk("notrim_len", CV, l);
      chk("out_data_clock_run", 0, stp);
      bus(1, 4'h1, 0, q);
      // Full scale from the adjust register, then from the pin
      for (i = 0; i < 4; i++) begin
         r = $random(seed);
         bus(1, 4'h2, {24'h0, r[7:0]}, q);
         repeat (4) @(posedge clk);
         chk("fs_adj", r[7:0], fs);
      end
      ext <= 1'h0;
      for (i = 0; i < 4; i++) begin
         r = $random(seed);
         rng <= r[0];
         repeat (6) @(posedge clk);
         chk("fs_pin", rng ? `ADCCAL_FS_NORMAL : `ADCCAL_FS_REDUCED, fs);
      end
      // Request while powered down is dropped for good
      bus(1, 4'h5, 32'h4, q);
      pd <= 1'h1;
      u_ctl.pulse(LO, HI);
      wrun(30, d, l);
      chk("pd_ign", 0, l);
      chk("irq_ign", 1, irq);
      bus(0, 4'h4, 0, q);
      chk("ign_flag", 1, q[2]);
      pd <= 1'h0;
      wrun(40, d, l);
      chk("pd_late", 0, l);
      // Power down during calibration waits for its end
      u_ctl.pulse(LO, 1);
      for (i = 0; i < 30 && cr !== 1'h1; i++) @(posedge clk);
      pd <= 1'h1;
      wrun(1, d, l);
      chk("pd_run", TR + CV, l);
      repeat (4) @(posedge clk);
      chk("pd_after", 1, apd);
      pd <= 1'h0;
      bus(0, 4'h7, 0, q);
      chk("unmapped", 0, q);
      // No sample clock at power-up, then it starts
      reset(0, 0, 0, 0);
      repeat (60) @(posedge clk);
      chk("noclk_pd", 1, apd);
      chk("noclk_run", 0, cr);
      cp <= 1'h1;
      wrun(100, d, l);
      chk("late_dly", 1, d > SH && d <= SH + 12);
      chk("late_len", TR + CV, l);
      tally_and_finish;
   end
endmodule
